// [rtl/serr_error_reporting.sv]
// System-error reporting: enables, status flags and hub special cycles.
//
// Behaviour
// [R1] Errors leave as a system-error special cycle on the hub port, no pin.
// [R2] Host-bridge errors report only while host command bit 8 is set.
// [R3] Each error occurrence yields exactly one special cycle; a repeat while its source is still pending adds no cycle here.
// [R4] Software keeps SMI and SCI off for conditions it enables here.
// [R5] Enable register at CBh, 8 bits, reset 00h, bits 7:6 reserved.
// [R6] Enable bit 5 reports main memory refresh overrun.
// [R7] Enable bit 4 reports target abort on our hub cycles.
// [R8] Enable bit 3 reports processor locked access to non-DRAM memory.
// [R9] Enable bit 2 reports AGP access outside the graphics aperture.
// [R10] Enable bit 1 reports outside-aperture access in 640KB-1MB or above top.
// [R11] Enable bit 0 reports invalid translation entry for aperture access.
// [R12] Every host-bridge system error sets host status bit 14.
// [R13] Received hub target abort also sets host status bit 12.
// [R14] AGP parity error reports under AGP cmd bit 8 and control bit 2.
// [R15] AGP target abort reports under AGP cmd bit 8, error enable bit 0.
// [R16] Simultaneous errors queue and are sent one at a time.
`timescale 1ns/1ps

module serr_error_reporting
  import serr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refresh_overrun,
  input wire logic hub_target_abort,
  input wire logic lock_nondram,
  input wire logic outside_aperture,
  input wire logic invalid_agp_access,
  input wire logic bad_translation,
  input wire logic agp_parity_error,
  input wire logic agp_target_abort,
  output logic special_cycle_valid,
  output logic [2:0] special_cycle_source,
  input wire logic special_cycle_ready,
  output logic irq
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  serr_state_s r;
  serr_state_s next_r;
  logic [NUM_EVENTS-1:0] ev;
  logic [NUM_EVENTS-1:0] ev_prev;
  logic [NUM_EVENTS-1:0] ev_rise;
  logic [NUM_EVENTS-1:0] reported;
  logic host_global;
  logic agp_global;
  logic wr;
  logic rd;
  logic hit;
  logic [2:0] pick;
  logic pick_any;
  logic [NUM_EVENTS-1:0] ev_enable;
  logic setup_rd;
  logic [31:0] rd_word;

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  // The source code on the hub port is three bits wide, so at most eight
  // sources can be told apart, and the read mux returns eight status bits.
  if (NUM_EVENTS > 8) begin : g_check_events
    $error("serr_error_reporting serves at most eight event sources");
  end
  // The gating loop below treats every index under the parity event as a
  // host-bridge event with its own enable bit.
  if (EV_AGP_PARITY != 6) begin : g_check_order
    $error("serr_error_reporting needs six host events below the bridge");
  end

  // ****************************************************************
  // Event capture.
  // ****************************************************************
  // Each event is a level from logic on this clock; its rising edge is one
  // occurrence, so a long level cannot send more than one cycle.
  assign ev = {agp_target_abort, agp_parity_error, refresh_overrun,
               hub_target_abort, lock_nondram, outside_aperture,
               invalid_agp_access, bad_translation};

  // The previous levels live in the state struct and reset to the idle
  // level of every event input, so no false edge follows reset.
  assign ev_prev = r.ev_prev;

  assign ev_rise = ev & ~ev_prev; // [R3]
  assign host_global = r.host_bridge_command[BIT_GLOBAL_SERR_EN];
  assign agp_global = r.agp_bridge_command[BIT_GLOBAL_SERR_EN];

  // ****************************************************************
  // Per-event gating by the individual and global enables.
  // ****************************************************************
  // Host-bridge events need their own enable bit and the global bit of the
  // host bridge command; the two bridge events have enable pairs of their
  // own. A dropped event leaves no status and no interrupt behind.
  for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_event
    if (g < EV_AGP_PARITY) begin : g_host
      assign ev_enable[g] = r.system_error_enable[g] // [R6] [R7] [R8]
          & host_global; // [R2] [R9] [R10] [R11]
    end else if (g == EV_AGP_PARITY) begin : g_parity
      assign ev_enable[g] = agp_global
          & r.bridge_control[BIT_BRIDGE_CONTROL_PARITY_SERR]; // [R14]
    end else begin : g_tabort
      assign ev_enable[g] = agp_global
          & r.agp_bridge_error_enable[BIT_AGP_TABORT_EN]; // [R15]
    end
    assign reported[g] = ev_rise[g] & ev_enable[g];
  end

  // ****************************************************************
  // Queue arbitration: lowest pending index goes first.
  // ****************************************************************
  always_comb begin
    pick = 3'h0;
    pick_any = 1'b0;
    for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
      if (r.pending[i]) begin
        pick = 3'(i);
        pick_any = 1'b1;
      end
    end
  end

  // ****************************************************************
  // APB decode.
  // ****************************************************************
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // A read is looked up in its setup cycle so that its data stands in a
  // register for the whole access phase.
  assign setup_rd = psel && !penable && !pwrite;

  always_comb begin
    case (paddr)
      ADDR_SYSTEM_ERROR_ENABLE, ADDR_HOST_BRIDGE_COMMAND,
      ADDR_HOST_BRIDGE_STATUS, ADDR_AGP_BRIDGE_COMMAND,
      ADDR_AGP_BRIDGE_STATUS, ADDR_BRIDGE_CONTROL,
      ADDR_AGP_BRIDGE_ERROR_ENABLE, ADDR_IRQ_STATUS,
      ADDR_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ****************************************************************
  // Read mux.
  // ****************************************************************
  always_comb begin
    case (paddr)
      ADDR_SYSTEM_ERROR_ENABLE:
        rd_word = {24'h000000, r.system_error_enable}; // [R5]
      ADDR_HOST_BRIDGE_COMMAND:
        rd_word = {16'h0000, r.host_bridge_command};
      ADDR_HOST_BRIDGE_STATUS:
        rd_word = {16'h0000, r.host_bridge_status};
      ADDR_AGP_BRIDGE_COMMAND:
        rd_word = {16'h0000, r.agp_bridge_command};
      ADDR_AGP_BRIDGE_STATUS:
        rd_word = {16'h0000, r.agp_bridge_status};
      ADDR_BRIDGE_CONTROL:
        rd_word = {24'h000000, r.bridge_control};
      ADDR_AGP_BRIDGE_ERROR_ENABLE:
        rd_word = {24'h000000, r.agp_bridge_error_enable};
      ADDR_IRQ_STATUS:
        rd_word = {24'h000000, r.irq_status};
      ADDR_IRQ_MASK:
        rd_word = {24'h000000, r.irq_mask};
      default:
        rd_word = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    next_r = r;

    // Software writes; the two bridge status registers are write-one-to-clear, the interrupt status ignores writes.
    if (wr && hit) begin
      case (paddr)
        ADDR_SYSTEM_ERROR_ENABLE: begin
          if (pstrb[0]) begin
            next_r.system_error_enable = pwdata[7:0]
                & SYSTEM_ERROR_ENABLE_WMASK; // [R5]
          end
        end
        ADDR_HOST_BRIDGE_COMMAND: begin
          if (pstrb[0]) begin
            next_r.host_bridge_command[7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            next_r.host_bridge_command[15:8] = pwdata[15:8];
          end
        end
        ADDR_HOST_BRIDGE_STATUS: begin
          if (pstrb[1]) begin
            next_r.host_bridge_status[15:8] =
                r.host_bridge_status[15:8] & ~pwdata[15:8];
          end
        end
        ADDR_AGP_BRIDGE_COMMAND: begin
          if (pstrb[0]) begin
            next_r.agp_bridge_command[7:0] = pwdata[7:0];
          end
          if (pstrb[1]) begin
            next_r.agp_bridge_command[15:8] = pwdata[15:8];
          end
        end
        ADDR_AGP_BRIDGE_STATUS: begin
          if (pstrb[1]) begin
            next_r.agp_bridge_status[15:8] =
                r.agp_bridge_status[15:8] & ~pwdata[15:8];
          end
        end
        ADDR_BRIDGE_CONTROL: begin
          if (pstrb[0]) begin
            next_r.bridge_control = pwdata[7:0];
          end
        end
        ADDR_AGP_BRIDGE_ERROR_ENABLE: begin
          if (pstrb[0]) begin
            next_r.agp_bridge_error_enable = pwdata[7:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (pstrb[0]) begin
            next_r.irq_mask = pwdata[NUM_EVENTS-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Reading the interrupt status clears only the bits that the read has
    // returned; an event that lands during the access stays recorded.
    if (rd && paddr == ADDR_IRQ_STATUS) begin
      next_r.irq_status = r.irq_status & ~r.prdata[NUM_EVENTS-1:0];
    end

    // Read data is taken at the setup edge and held until the next read.
    if (setup_rd) begin
      next_r.prdata = rd_word;
    end
    next_r.ev_prev = ev; // [R3]

    // Hardware sets win over software clears.
    if (|reported[5:0]) begin
      next_r.host_bridge_status[BIT_SIGNALLED_SERR] = 1'b1; // [R12]
    end
    if (reported[EV_HUB_TABORT]) begin
      next_r.host_bridge_status[BIT_RECEIVED_TABORT] = 1'b1; // [R13]
    end
    if (reported[EV_AGP_PARITY]) begin
      next_r.agp_bridge_status[BIT_SIGNALLED_SERR] = 1'b1; // [R14]
      next_r.agp_bridge_status[BIT_DETECTED_PARITY] = 1'b1; // [R14]
    end
    if (reported[EV_AGP_TABORT]) begin
      next_r.agp_bridge_status[BIT_SIGNALLED_SERR] = 1'b1; // [R15]
      next_r.agp_bridge_status[BIT_RECEIVED_TABORT] = 1'b1; // [R15]
    end
    next_r.irq_status = next_r.irq_status | reported;

    // Special-cycle queue: one pending bit per source, served in turn.
    if (r.special_cycle_valid && special_cycle_ready) begin
      next_r.special_cycle_valid = 1'b0; // [R3]
    end
    // A new offer starts only from an idle port, so one cycle without
    // valid separates two special cycles and none is ever repeated.
    if (!r.special_cycle_valid && pick_any) begin
      next_r.special_cycle_valid = 1'b1; // [R1]
      next_r.special_cycle_source = pick;
      next_r.pending[pick] = 1'b0; // [R16]
    end
    next_r.pending = next_r.pending | reported; // [R16]
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.system_error_enable <= SYSTEM_ERROR_ENABLE_RESET; // [R5]
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign prdata = r.prdata;
  assign special_cycle_valid = r.special_cycle_valid;
  assign special_cycle_source = r.special_cycle_source;
  assign irq = |(r.irq_status & r.irq_mask);

endmodule // serr_error_reporting

// [shared/serr_pkg.sv]
// Package of constants and carrier types for the system-error reporting block.
package serr_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB).
  // ****************************************************************
  // Register indices; each register takes one aligned word, so its byte
  // address is four times its index.
  localparam logic [9:0] IDX_SYSTEM_ERROR_ENABLE = 10'h0cb;
  localparam logic [9:0] IDX_HOST_BRIDGE_COMMAND = 10'h004;
  localparam logic [9:0] IDX_HOST_BRIDGE_STATUS = 10'h006;
  localparam logic [9:0] IDX_AGP_BRIDGE_COMMAND = 10'h104;
  localparam logic [9:0] IDX_AGP_BRIDGE_STATUS = 10'h106;
  localparam logic [9:0] IDX_BRIDGE_CONTROL = 10'h13e;
  localparam logic [9:0] IDX_AGP_BRIDGE_ERROR_ENABLE = 10'h140;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h200;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h204;
  localparam logic [11:0] ADDR_SYSTEM_ERROR_ENABLE = 12'h32c;
  localparam logic [11:0] ADDR_HOST_BRIDGE_COMMAND = 12'h010;
  localparam logic [11:0] ADDR_HOST_BRIDGE_STATUS = 12'h018;
  localparam logic [11:0] ADDR_AGP_BRIDGE_COMMAND = 12'h410;
  localparam logic [11:0] ADDR_AGP_BRIDGE_STATUS = 12'h418;
  localparam logic [11:0] ADDR_BRIDGE_CONTROL = 12'h4f8;
  localparam logic [11:0] ADDR_AGP_BRIDGE_ERROR_ENABLE = 12'h500;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h800;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h810;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam logic [7:0] SYSTEM_ERROR_ENABLE_RESET = 8'h00;
  localparam logic [7:0] SYSTEM_ERROR_ENABLE_WMASK = 8'h3f;
  localparam int BIT_GLOBAL_SERR_EN = 8;
  localparam int BIT_SIGNALLED_SERR = 14;
  localparam int BIT_RECEIVED_TABORT = 12;
  localparam int BIT_DETECTED_PARITY = 15;
  localparam int BIT_BRIDGE_CONTROL_PARITY_SERR = 2;
  localparam int BIT_AGP_TABORT_EN = 0;
  localparam int NUM_EVENTS = 8;

  // Event indices; 0..5 match the enable bits of system_error_enable.
  localparam int EV_BAD_TRANSLATION = 0;
  localparam int EV_INVALID_AGP = 1;
  localparam int EV_OUTSIDE_APERTURE = 2;
  localparam int EV_LOCK_NONDRAM = 3;
  localparam int EV_HUB_TABORT = 4;
  localparam int EV_REFRESH_OVERRUN = 5;
  localparam int EV_AGP_PARITY = 6;
  localparam int EV_AGP_TABORT = 7;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef struct packed {
    logic [7:0] bad_translation_entry;
    logic refresh_overrun;
    logic hub_target_abort;
    logic lock_nondram;
    logic outside_aperture;
    logic invalid_agp_access;
    logic bad_translation;
    logic agp_parity_error;
    logic agp_target_abort;
  } serr_events_s;

  typedef struct packed {
    logic [7:0] system_error_enable;
    logic [15:0] host_bridge_command;
    logic [15:0] host_bridge_status;
    logic [15:0] agp_bridge_command;
    logic [15:0] agp_bridge_status;
    logic [7:0] bridge_control;
    logic [7:0] agp_bridge_error_enable;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [NUM_EVENTS-1:0] pending;
    logic [NUM_EVENTS-1:0] ev_prev;
    logic special_cycle_valid;
    logic [2:0] special_cycle_source;
    logic [31:0] prdata;
  } serr_state_s;

endpackage

// [tb/serr_error_reporting_asserts.sv]
// Assertion checker for the system-error reporting block.
`timescale 1ns/1ps
module serr_asserts
  import serr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic refresh_overrun,
  input wire logic special_cycle_valid,
  input wire logic [2:0] special_cycle_source,
  input wire logic special_cycle_ready,
  input wire logic irq
);
  logic glob;
  logic [5:0] en;
  logic wr;
  logic host;
  assign wr = psel && penable && pwrite && pready;
  assign host = special_cycle_valid && special_cycle_source < 3'd6;
  // Shadow copies of the global and per-error enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob <= 1'b0;
      en <= 6'h00;
    end else if (wr && paddr == ADDR_HOST_BRIDGE_COMMAND && pstrb[1]) begin
      glob <= pwdata[8];
    end else if (wr && paddr == ADDR_SYSTEM_ERROR_ENABLE && pstrb[0]) begin
      en <= pwdata[5:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_offer5;
    special_cycle_valid && special_cycle_source == 3'd5;
  endsequence
  property p_hold;
    special_cycle_valid && !special_cycle_ready |=>
      special_cycle_valid && $stable(special_cycle_source);
  endproperty
  a_hold: assert property (p_hold) else $error("offer withdrawn");
  property p_drop;
    special_cycle_valid && special_cycle_ready |=> !special_cycle_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("offer repeated");
  property p_global;
    host |-> glob;
  endproperty
  a_global: assert property (p_global) else $error("global gate");
  property p_enable;
    host |-> en[special_cycle_source];
  endproperty
  a_enable: assert property (p_enable) else $error("per-error gate");
  property p_report;
    $rose(refresh_overrun) && en[5] && glob |-> ##[1:20] s_offer5;
  endproperty
  a_report: assert property (p_report) else $error("overrun lost");
  property p_mapped;
    psel && penable && paddr == ADDR_SYSTEM_ERROR_ENABLE |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("enable refused");
  property p_slverr;
    pslverr |-> psel && penable;
  endproperty
  a_slverr: assert property (p_slverr) else $error("stray error");
  property p_reset;
    $rose(presetn) |-> !special_cycle_valid && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("busy after reset");
endmodule // serr_asserts

bind serr_error_reporting serr_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .refresh_overrun(refresh_overrun),
  .special_cycle_valid(special_cycle_valid), .irq(irq),
  .special_cycle_source(special_cycle_source),
  .special_cycle_ready(special_cycle_ready)
);

// [tb/serr_hub_model.sv]
// Model of the hub that takes system-error special cycles.
`timescale 1ns/1ps
module serr_hub_model
  import serr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic special_cycle_valid,
  input wire logic [2:0] special_cycle_source,
  input wire logic slow,
  output logic special_cycle_ready
);
  int count;
  logic [2:0] log [0:31];
  logic [1:0] tick;
  // When slow, accept only one cycle in four.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 0;
      tick <= 2'd0;
      special_cycle_ready <= 1'b0;
    end else begin
      tick <= tick + 2'd1;
      special_cycle_ready <= !slow || tick == 2'd2;
      if (special_cycle_valid && special_cycle_ready) begin
        log[count[4:0]] <= special_cycle_source;
        count <= count + 1;
      end
    end
  end
endmodule // serr_hub_model

// [tb/testbench.sv]
// Self-checking testbench for the system-error reporting block.
`timescale 1ns/1ps
module testbench
  import serr_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] ev = 8'h00;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic [2:0] scs;
  logic pready, pslverr, scv, scr, irq, err;
  int fails = 0;
  int compares = 0;
  always #5 pclk = ~pclk;
  serr_error_reporting dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bad_translation(ev[0]), .invalid_agp_access(ev[1]),
    .outside_aperture(ev[2]), .lock_nondram(ev[3]),
    .hub_target_abort(ev[4]), .refresh_overrun(ev[5]),
    .agp_parity_error(ev[6]), .agp_target_abort(ev[7]),
    .special_cycle_valid(scv), .special_cycle_source(scs),
    .special_cycle_ready(scr), .irq(irq)
  );
  serr_hub_model hub (
    .pclk(pclk), .presetn(presetn), .special_cycle_valid(scv),
    .special_cycle_source(scs), .slow(slow), .special_cycle_ready(scr)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!pready && i < 50);
    err = pslverr;
    rdata = prdata;
    if (!pready) begin
      fails++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read data is taken at the access edge, where pready is seen high.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic fire(input logic [7:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 8'h00;
  endtask
  task automatic wait_hub(input int n);
    for (int i = 0; i < 200 && hub.count < n; i++) @(posedge pclk);
    if (hub.count < n) begin
      fails++;
      complete_run();
    end
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_SYSTEM_ERROR_ENABLE, 32'h0);
    // The bench drives no SMI or SCI messaging for any enabled condition.
    apb(ADDR_SYSTEM_ERROR_ENABLE, 1'b1, 32'hff);
    rd(ADDR_SYSTEM_ERROR_ENABLE, 32'h3f);
    fire(8'h3f);
    repeat (10) @(posedge pclk);
    chk(hub.count, 0);
    rd(ADDR_HOST_BRIDGE_STATUS, 32'h0);
    $display("test enables and global gate done");
    slow <= 1'b1;
    apb(ADDR_HOST_BRIDGE_COMMAND, 1'b1, 32'h100);
    for (int k = 0; k < 6; k++) begin
      fire(8'h01 << k);
      wait_hub(k + 1);
      chk(hub.log[k], k);
    end
    repeat (10) @(posedge pclk);
    chk(hub.count, 6);
    rd(ADDR_HOST_BRIDGE_STATUS, 32'h5000);
    slow <= 1'b0;
    fire(8'h21);
    wait_hub(8);
    chk({hub.log[6], hub.log[7]}, {3'd0, 3'd5});
    $display("test host errors done");
    apb(ADDR_AGP_BRIDGE_COMMAND, 1'b1, 32'h100);
    fire(8'h40);
    repeat (10) @(posedge pclk);
    chk(hub.count, 8);
    apb(ADDR_BRIDGE_CONTROL, 1'b1, 32'h4);
    apb(ADDR_AGP_BRIDGE_ERROR_ENABLE, 1'b1, 32'h1);
    fire(8'h40);
    wait_hub(9);
    fire(8'h80);
    wait_hub(10);
    chk({hub.log[8], hub.log[9]}, {3'd6, 3'd7});
    rd(ADDR_AGP_BRIDGE_STATUS, 32'hd000);
    $display("test bridge errors done");
    apb(ADDR_IRQ_MASK, 1'b1, 32'h0);
    @(negedge pclk);
    chk(irq, 1'b0);
    apb(ADDR_IRQ_MASK, 1'b1, 32'hff);
    @(negedge pclk);
    chk(irq, 1'b1);
    rd(ADDR_IRQ_STATUS, 32'hff);
    @(negedge pclk);
    chk(irq, 1'b0);
    apb(12'h300, 1'b1, 32'h1);
    chk(err, 1'b1);
    $display("test interrupt and unmapped done");
    complete_run();
  end
endmodule // testbench
